// ### dv/sri_sdram_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// sdram stand-in: command counts, spacing
module sri_sdram_model (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst,
  // pins
  input  wire sri_pkg::sri_sdram_t sdram,
  // observations
  output int                       refCnt,
  output int                       pallCnt,
  output int                       selfBad,
  output int                       gapPw,
  output int                       gapRcv,
  output int                       gapExit,
  output logic [15:0]              lastMode
);
  logic              prevCke;
  logic              exited;
  sri_pkg::sri_cmd_t prevCmd;
  int                nops;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      refCnt <= 0;
      pallCnt <= 0;
      selfBad <= 0;
      gapPw <= 0;
      gapRcv <= 0;
      gapExit <= 0;
      lastMode <= 16'h0;
      nops <= 0;
      prevCke <= 1'h1;
      exited <= 1'h0;
      prevCmd <= sri_pkg::CMD_NOP;
    end else begin
      prevCke <= sdram.cke;
      if (sdram.cke && !prevCke) begin
        nops <= 0;
        exited <= 1'h1;
      end else if (sdram.cmd == sri_pkg::CMD_NOP) begin
        nops <= nops + 1;
      end else begin
        nops <= 0;
        prevCmd <= sdram.cmd;
        exited <= 1'h0;
        if (!prevCke) selfBad <= selfBad + 1;
        if (exited) gapExit <= nops;
        if (prevCmd == sri_pkg::CMD_ALL_BANK_PRECHARGE_CMD) gapPw <= nops;
        if (prevCmd == sri_pkg::CMD_REF && sdram.cmd != sri_pkg::CMD_ALL_BANK_PRECHARGE_CMD) gapRcv <= nops;
        if (sdram.cmd == sri_pkg::CMD_REF && sdram.cke) refCnt <= refCnt + 1;
        if (sdram.cmd == sri_pkg::CMD_ALL_BANK_PRECHARGE_CMD) pallCnt <= pallCnt + 1;
        if (sdram.cmd == sri_pkg::CMD_MRS) lastMode <= sdram.addr;
      end
    end
  end
endmodule
`default_nettype wire

// ### dv/sri_sdram_refresh_init_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "sri_params.svh"
module sri_sdram_refresh_init_tb;
  logic                clock = 1'h0;
  logic                rst = 1'h1;
  logic [7:0]          regAddr = 8'h0;
  logic [31:0]         regWrData = 32'h0;
  logic                regWr = 1'h0;
  logic                regRd = 1'h0;
  logic                busBusy = 1'h0;
  logic [31:0]         regRdData;
  logic                refreshBusy;
  logic                bankClose;
  sri_pkg::sri_sdram_t sdram;
  int                  refCnt, pallCnt, selfBad, gapPw, gapRcv, gapExit;
  logic [15:0]         lastMode;
  logic [31:0]         d;
  logic [31:0]         modes [4] = '{32'h440, 32'h460, 32'h40, 32'h60};
  int                  errorCnt = 0;
  int                  checked = 0;
  int                  cyc = 0;
  int                  closes = 0;

  sri_sdram_refresh_init i_sri_sdram_refresh_init (
    .clock(clock), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .busBusy(busBusy), .refreshBusy(refreshBusy),
    .bankClose(bankClose), .sdram(sdram));
  sri_sdram_model i_sri_sdram_model (
    .clock(clock), .rst(rst), .sdram(sdram), .refCnt(refCnt), .pallCnt(pallCnt),
    .selfBad(selfBad), .gapPw(gapPw), .gapRcv(gapRcv), .gapExit(gapExit), .lastMode(lastMode));

  always #2.5 clock = ~clock;

  // ==========================================
  // hang guard, bank-close pulses
  always @(posedge clock) begin
    cyc++;
    if (bankClose === 1'h1) closes++;
    if (cyc == 20000) begin
      errorCnt++;
      print_verdict();
    end
  end

  // ==========================================
  // access and compare tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clock);
    regAddr <= a;
    regWrData <= v;
    regWr <= 1'h1;
    @(posedge clock);
    regWr <= 1'h0;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errorCnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clock);
    regRd <= 1'h0;
    #1 d = regRdData;
    cmp(d & m, e);
  endtask
  task automatic waitBusy(input logic lvl);
    int n;
    n = 0;
    while (refreshBusy !== lvl && n < 600) begin
      @(negedge clock);
      n++;
    end
    cmp(32'(refreshBusy), 32'(lvl));
  endtask
  task automatic print_verdict();
    if (errorCnt == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // main sequence
  initial begin
    int b;
    int c;
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    for (int a = 0; a < 8; a++) rdc(8'(a * 4), 32'hffffffff, 32'h0);
    cmp(32'(sdram), 32'({1'h1, sri_pkg::CMD_NOP, 16'h0}));
    // init with every mode pattern, pw=i rcv=3-i
    for (int i = 0; i < 4; i++) begin
      wr(`SRI_OFS_WAIT_CTRL, 32'(((3 - i) << 2) | i));
      wr(`SRI_OFS_MODE_WRITE, modes[i]);
      waitBusy(1'h1);
      waitBusy(1'h0);
      cmp(32'(refCnt), 32'(8 * (i + 1)));
      cmp(32'(pallCnt), 32'(i + 1));
      cmp(32'(gapPw), 32'(i));
      cmp(32'(gapRcv), 32'(3 - i));
      cmp(32'(lastMode), modes[i]);
      rdc(`SRI_OFS_MODE_WRITE, 32'hfff, modes[i]);
    end
    // auto-refresh, pw=1 rcv=2, divide by 16, three per request
    wr(`SRI_OFS_WAIT_CTRL, 32'h9);
    wr(`SRI_OFS_TIME_CONST, 32'h4);
    wr(`SRI_OFS_TIMER_COUNT, 32'h0);
    wr(`SRI_OFS_SDRAM_CTRL, 32'h1);
    wr(`SRI_OFS_TIMER_CTRL, 32'h12);
    b = refCnt;
    c = closes;
    waitBusy(1'h1);
    rdc(`SRI_OFS_TIMER_COUNT, 32'hff, 32'h0);
    waitBusy(1'h0);
    cmp(32'(refCnt - b), 32'h3);
    cmp(32'(closes - c), 32'h3);
    cmp(32'(gapPw), 32'h1);
    cmp(32'(gapRcv), 32'h2);
    // bus held across three timer requests
    @(posedge clock);
    busBusy <= 1'h1;
    b = refCnt;
    repeat (200) @(posedge clock);
    cmp(32'(refCnt - b), 32'h0);
    rdc(`SRI_OFS_STATUS, 32'h2, 32'h2);
    @(posedge clock);
    busBusy <= 1'h0;
    waitBusy(1'h1);
    waitBusy(1'h0);
    cmp(32'(refCnt - b), 32'h3);
    // self-refresh with rcv=3, requests pend meanwhile
    wr(`SRI_OFS_WAIT_CTRL, 32'hd);
    wr(`SRI_OFS_SDRAM_CTRL, 32'h3);
    b = refCnt;
    repeat (300) @(posedge clock);
    cmp(32'(sdram.cke), 32'h0);
    rdc(`SRI_OFS_STATUS, 32'h1, 32'h1);
    cmp(32'(gapPw), 32'h1);
    cmp(32'(refCnt - b), 32'h0);
    wr(`SRI_OFS_SDRAM_CTRL, 32'h1);
    waitBusy(1'h0);
    waitBusy(1'h1);
    waitBusy(1'h0);
    cmp(32'(gapExit > 3), 32'h1);
    cmp(32'(refCnt - b), 32'h3);
    cmp(32'(selfBad), 32'h0);
    // count preset to constant minus one, refresh within one tick
    wr(`SRI_OFS_TIMER_COUNT, 32'h3);
    b = cyc;
    waitBusy(1'h1);
    cmp(32'(cyc - b < 24), 32'h1);
    waitBusy(1'h0);
    // reset while self-refreshing
    wr(`SRI_OFS_SDRAM_CTRL, 32'h3);
    repeat (20) @(posedge clock);
    rst <= 1'h1;
    @(posedge clock);
    rst <= 1'h0;
    @(negedge clock);
    cmp(32'(sdram.cke), 32'h1);
    rdc(`SRI_OFS_SDRAM_CTRL, 32'hffffffff, 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire

// ### hw/sri_params.svh
`ifndef SRI_PARAMS_SVH
`define SRI_PARAMS_SVH

// ==========================================
// register port geometry
`define SRI_ADDR_W             8
`define SRI_DATA_W             32

// ==========================================
// register offsets (byte addresses)
`define SRI_OFS_TIMER_CTRL     8'h00
`define SRI_OFS_TIMER_COUNT    8'h04
`define SRI_OFS_TIME_CONST     8'h08
`define SRI_OFS_SDRAM_CTRL     8'h0c
`define SRI_OFS_WAIT_CTRL      8'h10
`define SRI_OFS_MODE_WRITE     8'h14
`define SRI_OFS_STATUS         8'h18

// ==========================================
// field positions
`define SRI_RRC_LSB            0
`define SRI_CKS_LSB            3
`define SRI_REFRESH_ENABLE_BIT_BIT           0
`define SRI_REFRESH_MODE_SELECT_BIT          1
`define SRI_PW_LSB             0
`define SRI_RCV_LSB            2
`define SRI_STAT_SELF_BIT      0
`define SRI_STAT_PEND_BIT      1
`define SRI_STAT_INIT_BIT      2
`define SRI_STAT_BUSY_BIT      3
`define SRI_A10_BIT            10

// ==========================================
// widths and reset values
`define SRI_CNT_W              8
`define SRI_MODE_W             12
`define SRI_SDADDR_W           16
`define SRI_PRESC_W            14
`define SRI_RST_CNT            8'h00
`define SRI_RST_TC             8'h00
`define SRI_RST_CKS            3'h0
`define SRI_RST_RRC            3'h0
`define SRI_RST_WAIT           2'h0
`define SRI_RST_MODE           12'h000

// ==========================================
// sequence counts
`define SRI_INIT_REFRESHES     4'h8

`endif

// ### hw/sri_pkg.sv
`default_nettype none
package sri_pkg;

  // ==========================================
  // sdram command lines, active low
  typedef struct packed {
    logic csN;
    logic rasN;
    logic casN;
    logic weN;
  } sri_cmd_t;

  localparam sri_cmd_t CMD_NOP  = 4'h7;
  localparam sri_cmd_t CMD_ALL_BANK_PRECHARGE_CMD = 4'h2;
  localparam sri_cmd_t CMD_REF  = 4'h1;
  localparam sri_cmd_t CMD_MRS  = 4'h0;

  // ==========================================
  // pins toward the sdram
  typedef struct packed {
    logic        cke;
    sri_cmd_t    cmd;
    logic [15:0] addr;
  } sri_sdram_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ALL_BANK_PRECHARGE_CMD, ST_PW, ST_REF, ST_RCV, ST_SELF, ST_SX, ST_MRS, ST_MRSW
  } sri_state_t;

  typedef enum logic [1:0] {
    OP_AUTO, OP_SELF, OP_INIT
  } sri_op_t;

endpackage
`default_nettype wire

// ### hw/sri_refresh_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "sri_params.svh"

module sri_refresh_timer (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 rst,
  // settings
  input  wire logic [2:0]           clkSel,
  input  wire logic [`SRI_CNT_W-1:0] timeConst,
  input  wire logic                 cntWr,
  input  wire logic [`SRI_CNT_W-1:0] cntWrData,
  // state
  output logic [`SRI_CNT_W-1:0]     count,
  output logic                      request
);

  logic [`SRI_PRESC_W-1:0] presc_ff;
  logic [`SRI_CNT_W-1:0]   count_ff;
  logic                    request_ff;
  logic [`SRI_PRESC_W-1:0] divMask;
  logic                    tick;

  // select 0 stops the timer, 1..7 divide by 4, 16 ... 16384
  assign divMask = (`SRI_PRESC_W'(1) << {clkSel, 1'b0}) - `SRI_PRESC_W'(1);
  assign tick    = (clkSel != 3'h0) && ((presc_ff & divMask) == divMask);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      presc_ff <= '0;
    end else begin
      presc_ff <= presc_ff + `SRI_PRESC_W'(1);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_ff   <= `SRI_RST_CNT;
      request_ff <= 1'b0;
    end else begin
      request_ff <= 1'b0;
      if (cntWr) begin
        count_ff <= cntWrData;
      end else if (clkSel != 3'h0 && count_ff == timeConst) begin
        count_ff   <= '0;
        request_ff <= 1'b1;
      end else if (tick) begin
        count_ff <= count_ff + `SRI_CNT_W'(1);
      end
    end
  end

  assign count   = count_ff;
  assign request = request_ff;

  property p_match_clear;
    @(posedge clock) disable iff (rst)
    (clkSel != 3'h0 && count_ff == timeConst && !cntWr) |=> (count_ff == '0 && request_ff);
  endproperty
  a_match_clear: assert property (p_match_clear) else $error("timer match did not clear and request");

endmodule

`default_nettype wire

// ### hw/sri_sdram_refresh_init.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "sri_params.svh"

// Behaviour
// - timer compared with constant each cycle while a clock is selected; on match request, clear, restart
// - each request runs the configured number of auto-refresh commands
// - selecting a clock makes the timer count from its current value
// - auto-refresh: all-bank precharge, precharge wait, then refresh command
// - no new command during recovery wait after refresh command
// - precharge wait state inserted when precharge wait is nonzero
// - mode select and enable both set enters self-refresh
// - self entry: precharge, wait, self command, then no accesses
// - clearing mode select leaves self-refresh, then recovery wait blocks commands
// - leaving self with enable still set resumes auto-refresh
// - power-on reset initializes registers and ends self-refresh
// - request during bus cycle waits until that cycle completes
// - newer request while one pends merges; earlier one discarded
// - mode register write drives zeros on address pins A12 upward
// - init: precharge, eight refreshes, mode set, two idle cycles after
// - auto-refresh runs when mode select clear and enable set
// - every refresh cycle leaves all banks treated as closed
module sri_sdram_refresh_init (
  // clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // register port
  input  wire logic [`SRI_ADDR_W-1:0]   regAddr,
  input  wire logic [`SRI_DATA_W-1:0]   regWrData,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic [`SRI_DATA_W-1:0]        regRdData,
  // bus cycle arbitration
  input  wire logic                     busBusy,
  output logic                          refreshBusy,
  output logic                          bankClose,
  // sdram pins
  output var sri_pkg::sri_sdram_t       sdram
);

  // ==========================================
  // configuration registers
  logic [2:0]             cks_ff;
  logic [2:0]             rrc_ff;
  logic [`SRI_CNT_W-1:0]  tc_ff;
  logic                   modeSel_ff;
  logic                   refEn_ff;
  logic [1:0]             pw_ff;
  logic [1:0]             rcv_ff;
  logic [`SRI_MODE_W-1:0] modeVal_ff;
  logic                   reqPend_ff;
  logic                   initReq_ff;

  // ==========================================
  // sequencer state
  sri_pkg::sri_state_t    state_ff;
  sri_pkg::sri_state_t    nxt_state;
  sri_pkg::sri_op_t       op_ff;
  sri_pkg::sri_op_t       nxt_op;
  logic [1:0]             wait_ff;
  logic [1:0]             nxt_wait;
  logic [3:0]             left_ff;
  logic [3:0]             nxt_left;
  sri_pkg::sri_cmd_t      nxt_cmd;
  logic [`SRI_SDADDR_W-1:0] nxt_addr;
  logic                   advance;
  logic                   startSeq;
  logic                   acceptAuto;
  logic                   acceptInit;

  // ==========================================
  // output registers
  sri_pkg::sri_sdram_t    sdram_ff;
  logic                   refreshBusy_ff;
  logic                   bankClose_ff;
  logic [`SRI_DATA_W-1:0] rdData_ff;

  logic [`SRI_CNT_W-1:0]  timerCount;
  logic                   timerReq;
  logic                   wrCtrl;
  logic                   wrCount;
  logic                   wrConst;
  logic                   wrSdCtrl;
  logic                   wrWait;
  logic                   wrMode;

  assign wrCtrl   = regWr && regAddr == `SRI_OFS_TIMER_CTRL;
  assign wrCount  = regWr && regAddr == `SRI_OFS_TIMER_COUNT;
  assign wrConst  = regWr && regAddr == `SRI_OFS_TIME_CONST;
  assign wrSdCtrl = regWr && regAddr == `SRI_OFS_SDRAM_CTRL;
  assign wrWait   = regWr && regAddr == `SRI_OFS_WAIT_CTRL;
  assign wrMode   = regWr && regAddr == `SRI_OFS_MODE_WRITE;

  sri_refresh_timer u_timer (
    .clock     (clock),
    .rst       (rst),
    .clkSel    (cks_ff),
    .timeConst (tc_ff),
    .cntWr     (wrCount),
    .cntWrData (regWrData[`SRI_CNT_W-1:0]),
    .count     (timerCount),
    .request   (timerReq)
  );

  // ==========================================
  // configuration; only power-on reset clears it
  // reset clears settings
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cks_ff     <= `SRI_RST_CKS;
      rrc_ff     <= `SRI_RST_RRC;
      tc_ff      <= `SRI_RST_TC;
      modeSel_ff <= 1'b0;
      refEn_ff   <= 1'b0;
      pw_ff      <= `SRI_RST_WAIT;
      rcv_ff     <= `SRI_RST_WAIT;
    end else begin
      if (wrCtrl) begin
        cks_ff <= regWrData[`SRI_CKS_LSB +: 3];
        rrc_ff <= regWrData[`SRI_RRC_LSB +: 3];
      end
      if (wrConst) begin
        tc_ff <= regWrData[`SRI_CNT_W-1:0];
      end
      if (wrSdCtrl) begin
        modeSel_ff <= regWrData[`SRI_REFRESH_MODE_SELECT_BIT];
        refEn_ff   <= regWrData[`SRI_REFRESH_ENABLE_BIT_BIT];
      end
      if (wrWait) begin
        pw_ff  <= regWrData[`SRI_PW_LSB +: 2];
        rcv_ff <= regWrData[`SRI_RCV_LSB +: 2];
      end
    end
  end

  // ==========================================
  // pending requests; a new event beats the clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reqPend_ff <= 1'b0;
      initReq_ff <= 1'b0;
      modeVal_ff <= `SRI_RST_MODE;
    end else begin
      if (timerReq) begin
        reqPend_ff <= 1'b1;
      end else if (acceptAuto) begin
        reqPend_ff <= 1'b0;
      end
      if (wrMode) begin
        initReq_ff <= 1'b1;
        modeVal_ff <= regWrData[`SRI_MODE_W-1:0];
      end else if (acceptInit) begin
        initReq_ff <= 1'b0;
      end
    end
  end

  // ==========================================
  // sequencer next state
  always_comb begin
    nxt_state  = state_ff;
    nxt_op     = op_ff;
    nxt_wait   = wait_ff;
    nxt_left   = left_ff;
    nxt_cmd    = sri_pkg::CMD_NOP;
    nxt_addr   = '0;
    advance    = 1'b0;
    startSeq   = 1'b0;
    acceptAuto = 1'b0;
    acceptInit = 1'b0;
    case (state_ff)
      sri_pkg::ST_IDLE: begin
        if (!busBusy) begin
          if (initReq_ff) begin
            acceptInit = 1'b1;
            startSeq   = 1'b1;
            nxt_op     = sri_pkg::OP_INIT;
            nxt_left   = `SRI_INIT_REFRESHES;
          end else if (refEn_ff && modeSel_ff) begin
            startSeq = 1'b1;
            nxt_op   = sri_pkg::OP_SELF;
          end else if (refEn_ff && reqPend_ff) begin
            acceptAuto = 1'b1;
            startSeq   = 1'b1;
            nxt_op     = sri_pkg::OP_AUTO;
            nxt_left   = {1'b0, rrc_ff} + 4'h1;
          end
        end
        if (startSeq) begin
          nxt_state              = sri_pkg::ST_ALL_BANK_PRECHARGE_CMD;
          nxt_cmd                = sri_pkg::CMD_ALL_BANK_PRECHARGE_CMD;
          nxt_addr[`SRI_A10_BIT] = 1'b1;
        end
      end
      sri_pkg::ST_ALL_BANK_PRECHARGE_CMD: begin
        if (pw_ff != 2'h0) begin
          nxt_state = sri_pkg::ST_PW;
          nxt_wait  = pw_ff - 2'h1;
        end else begin
          advance = 1'b1;
        end
      end
      sri_pkg::ST_REF: begin
        if (rcv_ff != 2'h0) begin
          nxt_state = sri_pkg::ST_RCV;
          nxt_wait  = rcv_ff - 2'h1;
        end else begin
          advance = 1'b1;
        end
      end
      sri_pkg::ST_PW, sri_pkg::ST_RCV: begin
        if (wait_ff == 2'h0) begin
          advance = 1'b1;
        end else begin
          nxt_wait = wait_ff - 2'h1;
        end
      end
      sri_pkg::ST_SELF: begin
        if (!modeSel_ff || !refEn_ff) begin
          nxt_state = sri_pkg::ST_SX;
          nxt_wait  = rcv_ff;
        end
      end
      sri_pkg::ST_SX: begin
        if (wait_ff == 2'h0) begin
          nxt_state = sri_pkg::ST_IDLE;
        end else begin
          nxt_wait = wait_ff - 2'h1;
        end
      end
      sri_pkg::ST_MRS: begin
        nxt_state = sri_pkg::ST_MRSW;
      end
      sri_pkg::ST_MRSW: begin
        nxt_state = sri_pkg::ST_IDLE;
      end
      default: begin
        nxt_state = sri_pkg::ST_IDLE;
      end
    endcase
    if (advance) begin
      if (op_ff == sri_pkg::OP_SELF) begin
        nxt_state = sri_pkg::ST_SELF;
        nxt_cmd   = sri_pkg::CMD_REF;
      end else if (left_ff != 4'h0) begin
        nxt_state = sri_pkg::ST_REF;
        nxt_cmd   = sri_pkg::CMD_REF;
        nxt_left  = left_ff - 4'h1;
      end else if (op_ff == sri_pkg::OP_INIT) begin
        nxt_state = sri_pkg::ST_MRS;
        nxt_cmd   = sri_pkg::CMD_MRS;
        nxt_addr  = {{(`SRI_SDADDR_W-`SRI_MODE_W){1'b0}}, modeVal_ff};
      end else begin
        nxt_state = sri_pkg::ST_IDLE;
      end
    end
  end

  // ==========================================
  // sequencer registers
  // reset ends self-refresh
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_ff <= sri_pkg::ST_IDLE;
      op_ff    <= sri_pkg::OP_AUTO;
      wait_ff  <= 2'h0;
      left_ff  <= 4'h0;
    end else begin
      state_ff <= nxt_state;
      op_ff    <= nxt_op;
      wait_ff  <= nxt_wait;
      left_ff  <= nxt_left;
    end
  end

  // ==========================================
  // pin and status outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sdram_ff.cke   <= 1'b1;
      sdram_ff.cmd   <= sri_pkg::CMD_NOP;
      sdram_ff.addr  <= '0;
      refreshBusy_ff <= 1'b0;
      bankClose_ff   <= 1'b0;
    end else begin
      sdram_ff.cke   <= nxt_state != sri_pkg::ST_SELF;
      sdram_ff.cmd   <= nxt_cmd;
      sdram_ff.addr  <= nxt_addr;
      refreshBusy_ff <= nxt_state != sri_pkg::ST_IDLE;
      bankClose_ff   <= nxt_cmd == sri_pkg::CMD_REF;
    end
  end

  // ==========================================
  // register read, data in the following cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdData_ff <= '0;
    end else begin
      rdData_ff <= '0;
      if (regRd) begin
        case (regAddr)
          `SRI_OFS_TIMER_CTRL: begin
            rdData_ff[`SRI_CKS_LSB +: 3] <= cks_ff;
            rdData_ff[`SRI_RRC_LSB +: 3] <= rrc_ff;
          end
          `SRI_OFS_TIMER_COUNT: rdData_ff[`SRI_CNT_W-1:0] <= timerCount;
          `SRI_OFS_TIME_CONST:  rdData_ff[`SRI_CNT_W-1:0] <= tc_ff;
          `SRI_OFS_SDRAM_CTRL: begin
            rdData_ff[`SRI_REFRESH_MODE_SELECT_BIT] <= modeSel_ff;
            rdData_ff[`SRI_REFRESH_ENABLE_BIT_BIT]  <= refEn_ff;
          end
          `SRI_OFS_WAIT_CTRL: begin
            rdData_ff[`SRI_PW_LSB +: 2]  <= pw_ff;
            rdData_ff[`SRI_RCV_LSB +: 2] <= rcv_ff;
          end
          `SRI_OFS_MODE_WRITE:  rdData_ff[`SRI_MODE_W-1:0] <= modeVal_ff;
          `SRI_OFS_STATUS: begin
            rdData_ff[`SRI_STAT_SELF_BIT] <= state_ff == sri_pkg::ST_SELF;
            rdData_ff[`SRI_STAT_PEND_BIT] <= reqPend_ff;
            rdData_ff[`SRI_STAT_INIT_BIT] <= initReq_ff;
            rdData_ff[`SRI_STAT_BUSY_BIT] <= refreshBusy_ff;
          end
          default: rdData_ff <= '0;
        endcase
      end
    end
  end

  assign regRdData   = rdData_ff;
  assign refreshBusy = refreshBusy_ff;
  assign bankClose   = bankClose_ff;
  assign sdram       = sdram_ff;

  // ==========================================
  // checks
  logic isNop;
  logic isPall;
  logic isRef;
  logic isMrs;

  assign isNop  = sdram_ff.cmd == sri_pkg::CMD_NOP;
  assign isPall = sdram_ff.cmd == sri_pkg::CMD_ALL_BANK_PRECHARGE_CMD;
  assign isRef  = sdram_ff.cmd == sri_pkg::CMD_REF;
  assign isMrs  = sdram_ff.cmd == sri_pkg::CMD_MRS;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_two_idle;
    isNop ##1 isNop;
  endsequence

  sequence s_three_idle;
    isNop [*3];
  endsequence

  property p_all_bank_precharge_cmd_ref;
    isPall |-> ##[1:4] isRef;
  endproperty
  a_all_bank_precharge_cmd_ref: assert property (p_all_bank_precharge_cmd_ref) else $error("precharge not followed by refresh");

  property p_pw_two;
    isPall && pw_ff == 2'h2 |=> s_two_idle ##1 isRef;
  endproperty
  a_pw_two: assert property (p_pw_two) else $error("precharge wait length wrong");

  property p_recovery;
    isRef && sdram_ff.cke && rcv_ff == 2'h3 |=> s_three_idle;
  endproperty
  a_recovery: assert property (p_recovery) else $error("command inside recovery wait");

  property p_self_quiet;
    state_ff == sri_pkg::ST_SELF && modeSel_ff && refEn_ff |=> !sdram_ff.cke && isNop;
  endproperty
  a_self_quiet: assert property (p_self_quiet) else $error("access during self-refresh");

  property p_self_entry;
    state_ff == sri_pkg::ST_IDLE && !busBusy && !initReq_ff && refEn_ff && modeSel_ff |=> isPall;
  endproperty
  a_self_entry: assert property (p_self_entry) else $error("self-refresh entry not started");

  property p_self_exit;
    state_ff == sri_pkg::ST_SELF && !modeSel_ff && rcv_ff == 2'h3 |=> sdram_ff.cke ##0 s_three_idle;
  endproperty
  a_self_exit: assert property (p_self_exit) else $error("self-refresh exit wait wrong");

  property p_busy_hold;
    state_ff == sri_pkg::ST_IDLE && busBusy |=> isNop && !refreshBusy_ff;
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("refresh started during bus cycle");

  property p_pend_keep;
    timerReq && reqPend_ff |=> reqPend_ff;
  endproperty
  a_pend_keep: assert property (p_pend_keep) else $error("merged request lost");

  property p_mrs_addr;
    isMrs |-> sdram_ff.addr[`SRI_SDADDR_W-1:`SRI_MODE_W] == '0 && sdram_ff.addr[`SRI_MODE_W-1:0] == modeVal_ff;
  endproperty
  a_mrs_addr: assert property (p_mrs_addr) else $error("mode write address wrong");

  property p_mrs_idle;
    isMrs |=> isNop;
  endproperty
  a_mrs_idle: assert property (p_mrs_idle) else $error("no idle after mode set");

  property p_init_first;
    state_ff == sri_pkg::ST_IDLE && !busBusy && initReq_ff |=> op_ff == sri_pkg::OP_INIT && !initReq_ff;
  endproperty
  a_init_first: assert property (p_init_first) else $error("init not given priority");

endmodule

`default_nettype wire
